// ===== verilog/drw_defines.svh
`ifndef DRW_DEFINES_SVH
`define DRW_DEFINES_SVH
`define DRW_WORD_RST       16'h0000
`define DRW_FREQ_MAX       16'h9C40
`define DRW_EXT_ZERO       8'h00
`define DRW_EXT_ONE        8'h01
`define DRW_EXT_TWELVE     8'h0C
`define DRW_TSRC_A         8'h03
`define DRW_TSRC_B         8'h05
`define DRW_RES_A          8'h01
`define DRW_RES_B          8'h0B
`define DRW_FAULT_MAX      8'h07
`define DRW_MON_ITEMS      6
`define DRW_REFRESH_CYCLES 16
`define DRW_OFS_WORD0      8'h00
`define DRW_OFS_CTRL       8'h24
`define DRW_OFS_STAT       8'h28
`define DRW_OFS_RB0        8'h2C
`define DRW_CTRL_MON       0
`define DRW_CTRL_VOL       1
`define DRW_CTRL_NV        2
`define DRW_CTRL_EXE       3
`define DRW_STAT_VOL       0
`define DRW_STAT_NV        1
`define DRW_STAT_INS       2
`endif

// ===== verilog/drw_pkg.sv
`default_nettype none
package drw_pkg;
  typedef logic [15:0] drw_word_t;
  typedef enum logic [1:0] {DRW_UNIT_CENTIHZ, DRW_UNIT_RPM, DRW_UNIT_DECI_RPM} drw_unit_t;
  typedef enum logic [1:0] {DRW_INS_IDLE, DRW_INS_WAIT, DRW_INS_DONE} drw_ins_state_t;
endpackage
`default_nettype wire

// ===== verilog/drw_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface drw_link_if;
  logic             refresh;
  logic [8:0][15:0] wr_words;
  logic             monitor_request;
  logic             volatile_write_request;
  logic             nonvolatile_write_request;
  logic             instruction_execute_request;
  logic [7:0][15:0] rd_words;
  logic             volatile_write_done;
  logic             nonvolatile_write_done;
  logic             instruction_done;
  modport master (
    output refresh, wr_words, monitor_request, volatile_write_request,
           nonvolatile_write_request, instruction_execute_request,
    input  rd_words, volatile_write_done, nonvolatile_write_done, instruction_done
  );
  modport drive (
    input  refresh, wr_words, monitor_request, volatile_write_request,
           nonvolatile_write_request, instruction_execute_request,
    output rd_words, volatile_write_done, nonvolatile_write_done, instruction_done
  );
endinterface
`default_nettype wire

// ===== verilog/drw_mon_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "drw_defines.svh"
module drw_mon_seq #(
  parameter int ITEMS = `DRW_MON_ITEMS
) (
  // Clock and reset
  input  wire logic                ref_clk_in,
  input  wire logic                reset_in,
  // Control
  input  wire logic                start_in,
  input  wire logic [ITEMS-1:0][7:0] codes_in,
  output logic                     busy_out,
  // Monitor source
  output logic [7:0]               mon_code_out,
  output logic                     mon_req_out,
  input  wire logic [15:0]         mon_data_in,
  input  wire logic                mon_ack_in,
  // Result
  output logic                     wr_en_out,
  output logic [2:0]               wr_idx_out,
  output logic [15:0]              wr_data_out
);
  logic       busy_r, busy_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic [7:0] code_r, code_nxt;
  logic       wr_r, wr_nxt;
  logic [15:0] data_r, data_nxt;

  always_comb begin
    busy_nxt = busy_r;
    idx_nxt  = idx_r;
    code_nxt = code_r;
    wr_nxt   = 1'b0;
    data_nxt = data_r;
    if (!busy_r) begin
      if (start_in) begin
        busy_nxt = 1'b1;
        idx_nxt  = 3'h0;
        code_nxt = codes_in[0];
      end
    end else if (mon_ack_in) begin
      wr_nxt   = 1'b1;
      data_nxt = mon_data_in;
      if (idx_r == 3'(ITEMS - 1)) begin
        busy_nxt = 1'b0;
      end else begin
        idx_nxt  = idx_r + 3'h1;
        code_nxt = codes_in[idx_r + 3'h1];
      end
    end
  end

  // Result index trails the item index by one edge
  logic [2:0] widx_r;
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      busy_r <= 1'b0;
      idx_r  <= 3'h0;
      widx_r <= 3'h0;
      code_r <= 8'h00;
      wr_r   <= 1'b0;
      data_r <= 16'h0000;
    end else begin
      busy_r <= busy_nxt;
      idx_r  <= idx_nxt;
      widx_r <= idx_r;
      code_r <= code_nxt;
      wr_r   <= wr_nxt;
      data_r <= data_nxt;
    end
  end

  assign busy_out     = busy_r;
  assign mon_req_out  = busy_r;
  assign mon_code_out = code_r;
  assign wr_en_out    = wr_r;
  assign wr_idx_out   = widx_r;
  assign wr_data_out  = data_r;
endmodule
`default_nettype wire

// ===== verilog/drw_drive_end.sv
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "drw_defines.svh"
module drw_drive_end
  import drw_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        reset_in,
  // Link to master station
  drw_link_if.drive        link,
  // Drive parameters
  input  wire logic [7:0]  link_extension_setting_in,
  input  wire logic [7:0]  torque_source_selection_in,
  input  wire logic        sign_selection_param_in,
  input  wire logic [7:0]  resolution_switchover_param_in,
  input  wire logic        speed_display_en_in,
  input  wire logic        torque_control_in,
  input  wire logic        vector_control_in,
  // Committed setpoint
  output logic [15:0]      freq_ram_out,
  output logic [15:0]      freq_nv_out,
  output logic             reverse_out,
  output drw_unit_t        setpoint_unit_out,
  output logic [15:0]      torque_value_volatile_param_out,
  output logic [15:0]      torque_value_nonvolatile_param_out,
  // Instruction execution
  output logic             instr_req_out,
  output logic [15:0]      instr_code_out,
  output logic [7:0]       instr_ext_out,
  output logic [15:0]      instr_operand_out,
  input  wire logic        instr_ack_in,
  // Fault history
  output logic [2:0]       fault_index_out,
  output logic             fault_index_valid_out,
  // Monitor source
  output logic [7:0]       mon_code_out,
  output logic             mon_req_out,
  input  wire logic [15:0] mon_data_in,
  input  wire logic        mon_ack_in
);
  // Sampled link image
  logic [8:0][15:0] w_r, w_nxt;
  logic [3:0]       req_r, req_nxt, req_q_r;

  always_comb begin
    w_nxt   = w_r;
    req_nxt = req_r;
    if (link.refresh) begin
      w_nxt   = link.wr_words;
      req_nxt = {link.instruction_execute_request, link.nonvolatile_write_request,
                 link.volatile_write_request, link.monitor_request};
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      w_r     <= '0;
      req_r   <= 4'h0;
      req_q_r <= 4'h0;
    end else begin
      w_r     <= w_nxt;
      req_r   <= req_nxt;
      req_q_r <= req_r;
    end
  end

  logic [3:0] rise;
  assign rise = req_r & ~req_q_r;
  // Setpoint commit
  logic [15:0] fram_r, fram_nxt, fnv_r, fnv_nxt, tram_r, tram_nxt, tnv_r, tnv_nxt;
  logic        rev_r, rev_nxt, vdone_r, vdone_nxt, ndone_r, ndone_nxt;
  drw_unit_t   unit_r, unit_nxt;
  logic        torque_mode, commit, in_range;

  always_comb begin
    torque_mode = torque_control_in &&
                  (link_extension_setting_in == `DRW_EXT_ZERO ||
                   link_extension_setting_in == `DRW_EXT_ONE ||
                   link_extension_setting_in == `DRW_EXT_TWELVE) &&
                  (torque_source_selection_in == `DRW_TSRC_A ||
                   torque_source_selection_in == `DRW_TSRC_B);
    commit   = rise[`DRW_CTRL_VOL] | rise[`DRW_CTRL_NV];
    fram_nxt = fram_r;
    fnv_nxt  = fnv_r;
    tram_nxt = tram_r;
    tnv_nxt  = tnv_r;
    rev_nxt  = rev_r;
    if (vector_control_in && (resolution_switchover_param_in == `DRW_RES_A ||
        resolution_switchover_param_in == `DRW_RES_B)) begin
      unit_nxt = DRW_UNIT_DECI_RPM;
    end else if (speed_display_en_in) begin
      unit_nxt = DRW_UNIT_RPM;
    end else begin
      unit_nxt = DRW_UNIT_CENTIHZ;
    end
    // Out-of-range unsigned frequency keeps the previous setpoint
    in_range = sign_selection_param_in || unit_nxt != DRW_UNIT_CENTIHZ ||
               w_r[1] <= `DRW_FREQ_MAX;
    if (commit && torque_mode) begin
      tram_nxt = w_r[1];
      tnv_nxt  = w_r[1];
    end else if (commit && in_range) begin
      fram_nxt = w_r[1];
      if (rise[`DRW_CTRL_NV]) begin
        fnv_nxt = w_r[1];
      end
      rev_nxt = sign_selection_param_in & w_r[1][15];
    end
    // Done flag follows its request; set wins over the clear
    vdone_nxt = (vdone_r & req_r[`DRW_CTRL_VOL]) | rise[`DRW_CTRL_VOL];
    ndone_nxt = (ndone_r & req_r[`DRW_CTRL_NV]) | rise[`DRW_CTRL_NV];
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      fram_r  <= `DRW_WORD_RST;
      fnv_r   <= `DRW_WORD_RST;
      tram_r  <= `DRW_WORD_RST;
      tnv_r   <= `DRW_WORD_RST;
      rev_r   <= 1'b0;
      unit_r  <= DRW_UNIT_CENTIHZ;
      vdone_r <= 1'b0;
      ndone_r <= 1'b0;
    end else begin
      fram_r  <= fram_nxt;
      fnv_r   <= fnv_nxt;
      tram_r  <= tram_nxt;
      tnv_r   <= tnv_nxt;
      rev_r   <= rev_nxt;
      unit_r  <= unit_nxt;
      vdone_r <= vdone_nxt;
      ndone_r <= ndone_nxt;
    end
  end

  // Instruction execution
  drw_ins_state_t ins_r, ins_nxt;
  logic [15:0]    icode_r, icode_nxt, iop_r, iop_nxt;
  logic [7:0]     iext_r, iext_nxt;
  logic [1:0]     iflag_r, iflag_nxt;

  always_comb begin
    ins_nxt   = ins_r;
    icode_nxt = icode_r;
    iext_nxt  = iext_r;
    iop_nxt   = iop_r;
    case (ins_r)
      DRW_INS_IDLE: begin
        if (rise[`DRW_CTRL_EXE]) begin
          ins_nxt = DRW_INS_WAIT;
          iop_nxt = w_r[3];
          iext_nxt  = 8'h00;
          icode_nxt = w_r[2];
          if (link_extension_setting_in != `DRW_EXT_ZERO) begin
            iext_nxt  = w_r[2][15:8];
            icode_nxt = {8'h00, w_r[2][7:0]};
          end
        end
      end
      DRW_INS_WAIT: begin
        if (instr_ack_in) begin
          ins_nxt = DRW_INS_DONE;
        end
      end
      default: begin
        if (!req_r[`DRW_CTRL_EXE]) begin
          ins_nxt = DRW_INS_IDLE;
        end
      end
    endcase
    iflag_nxt = {ins_nxt == DRW_INS_DONE, ins_nxt == DRW_INS_WAIT};
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ins_r   <= DRW_INS_IDLE;
      icode_r <= `DRW_WORD_RST;
      iext_r  <= 8'h00;
      iop_r   <= `DRW_WORD_RST;
      iflag_r <= 2'h0;
    end else begin
      ins_r   <= ins_nxt;
      icode_r <= icode_nxt;
      iext_r  <= iext_nxt;
      iop_r   <= iop_nxt;
      iflag_r <= iflag_nxt;
    end
  end

  // Monitor fetch and read-back words
  logic [7:0][15:0] rb_r, rb_nxt;
  logic             m_wr;
  logic [2:0]       m_idx;
  logic [15:0]      m_data;

  drw_mon_seq drw_mon_seq_inst (
    .ref_clk_in  (ref_clk_in),
    .reset_in    (reset_in),
    .start_in    (rise[`DRW_CTRL_MON]),
    .codes_in    ({w_r[7][7:0], w_r[6][7:0], w_r[5][7:0], w_r[4][7:0],
                   w_r[0][15:8], w_r[0][7:0]}),
    .busy_out    (),
    .mon_code_out(mon_code_out),
    .mon_req_out (mon_req_out),
    .mon_data_in (mon_data_in),
    .mon_ack_in  (mon_ack_in),
    .wr_en_out   (m_wr),
    .wr_idx_out  (m_idx),
    .wr_data_out (m_data)
  );

  always_comb begin
    rb_nxt = rb_r;
    if (m_wr) begin
      // Items 0-1 land in words 0-1, items 2-5 skip to words 4-7
      rb_nxt[(m_idx < 3'h2) ? m_idx : m_idx + 3'h2] = m_data;
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rb_r <= '0;
    end else begin
      rb_r <= rb_nxt;
    end
  end

  // Fault record select; high selections flagged as unreliable
  logic [2:0] fidx_r;
  logic       fval_r;
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      fidx_r <= 3'h0;
      fval_r <= 1'b1;
    end else begin
      fidx_r <= w_r[8][10:8];
      fval_r <= w_r[8][15:8] <= `DRW_FAULT_MAX;
    end
  end

  assign link.rd_words                  = rb_r;
  assign link.volatile_write_done       = vdone_r;
  assign link.nonvolatile_write_done    = ndone_r;
  assign link.instruction_done          = iflag_r[1];
  assign freq_ram_out                   = fram_r;
  assign freq_nv_out                    = fnv_r;
  assign reverse_out                    = rev_r;
  assign setpoint_unit_out              = unit_r;
  assign torque_value_volatile_param_out    = tram_r;
  assign torque_value_nonvolatile_param_out = tnv_r;
  assign instr_req_out                  = iflag_r[0];
  assign instr_code_out                 = icode_r;
  assign instr_ext_out                  = iext_r;
  assign instr_operand_out              = iop_r;
  assign fault_index_out                = fidx_r;
  assign fault_index_valid_out          = fval_r;
endmodule
`default_nettype wire

// ===== verilog/drw_master_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "drw_defines.svh"
module drw_master_end #(
  parameter int REFRESH_CYCLES = `DRW_REFRESH_CYCLES
) (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        reset_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hwdata_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // Link to drive
  drw_link_if.master       link
);
  logic [8:0][15:0] w_r, w_nxt, lw_r;
  logic [3:0]       ctrl_r, ctrl_nxt, lreq_r;
  logic [7:0][15:0] rb_r, rb_nxt;
  logic [2:0]       stat_r, stat_nxt;
  logic [7:0]       addr_r, addr_nxt;
  logic             wp_r, wp_nxt, tick;
  logic [31:0]      rd_r, rd_nxt;
  logic [15:0]      cnt_r, cnt_nxt;
  logic             ref_r;

  assign tick = (cnt_r == 16'(REFRESH_CYCLES - 1));

  always_comb begin
    w_nxt    = w_r;
    ctrl_nxt = ctrl_r;
    rb_nxt   = rb_r;
    stat_nxt = stat_r;
    rd_nxt   = rd_r;
    cnt_nxt  = tick ? 16'h0000 : cnt_r + 16'h0001;
    addr_nxt = addr_r;
    wp_nxt   = 1'b0;
    if (wp_r) begin
      if (addr_r < `DRW_OFS_CTRL) begin
        w_nxt[addr_r[5:2]] = hwdata_in[15:0];
      end else if (addr_r == `DRW_OFS_CTRL) begin
        ctrl_nxt = hwdata_in[3:0];
      end
    end
    if (tick) begin
      rb_nxt   = link.rd_words;
      stat_nxt = {link.instruction_done, link.nonvolatile_write_done,
                  link.volatile_write_done};
    end
    if (hsel_in && htrans_in[1] && hready_in) begin
      addr_nxt = haddr_in[7:0];
      wp_nxt   = hwrite_in;
      rd_nxt   = 32'h0000_0000;
      // Read sees a write finishing in this same cycle
      if (haddr_in[31:8] != 24'h000000) begin
        rd_nxt = 32'h0000_0000;
      end else if (haddr_in[7:0] < `DRW_OFS_CTRL) begin
        rd_nxt = {16'h0000, w_nxt[haddr_in[5:2]]};
      end else if (haddr_in[7:0] == `DRW_OFS_CTRL) begin
        rd_nxt = {28'h0000000, ctrl_nxt};
      end else if (haddr_in[7:0] == `DRW_OFS_STAT) begin
        rd_nxt = {29'h0000000, stat_nxt};
      end else if (haddr_in[7:0] >= `DRW_OFS_RB0 && haddr_in[7:0] < 8'h4C) begin
        rd_nxt = {16'h0000, rb_nxt[3'(haddr_in[7:2] - 6'h0B)]};
      end
      if (haddr_in[31:8] != 24'h000000) begin
        wp_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      w_r    <= '0;
      lw_r   <= '0;
      ctrl_r <= 4'h0;
      lreq_r <= 4'h0;
      rb_r   <= '0;
      stat_r <= 3'h0;
      addr_r <= 8'h00;
      wp_r   <= 1'b0;
      rd_r   <= 32'h0000_0000;
      cnt_r  <= 16'h0000;
      ref_r  <= 1'b0;
    end else begin
      w_r    <= w_nxt;
      ctrl_r <= ctrl_nxt;
      rb_r   <= rb_nxt;
      stat_r <= stat_nxt;
      addr_r <= addr_nxt;
      wp_r   <= wp_nxt;
      rd_r   <= rd_nxt;
      cnt_r  <= cnt_nxt;
      ref_r  <= tick;
      if (tick) begin
        lw_r   <= w_r;
        lreq_r <= ctrl_r;
      end
    end
  end

  assign hrdata_out                       = rd_r;
  assign hreadyout_out                    = 1'b1;
  assign hresp_out                        = 1'b0;
  assign link.refresh                     = ref_r;
  assign link.wr_words                    = lw_r;
  assign link.monitor_request             = lreq_r[`DRW_CTRL_MON];
  assign link.volatile_write_request      = lreq_r[`DRW_CTRL_VOL];
  assign link.nonvolatile_write_request   = lreq_r[`DRW_CTRL_NV];
  assign link.instruction_execute_request = lreq_r[`DRW_CTRL_EXE];
endmodule
`default_nettype wire

// ===== tb/drw_chk.sv
`timescale 1ns/1ps
`default_nettype none
module drw_chk #(
  parameter int REFRESH_CYCLES = 16
) (
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             reset_in,
  // Master to drive
  input  wire logic             refresh,
  input  wire logic [8:0][15:0] wr_words,
  input  wire logic             monitor_request,
  input  wire logic             volatile_write_request,
  input  wire logic             nonvolatile_write_request,
  input  wire logic             instruction_execute_request,
  // Drive to master
  input  wire logic [7:0][15:0] rd_words,
  input  wire logic             volatile_write_done,
  input  wire logic             nonvolatile_write_done,
  input  wire logic             instruction_done
);
  logic [7:0] gap_r;
  logic [7:0] gap_nxt;
  always_comb begin
    gap_nxt = refresh ? 8'h00 : gap_r + 8'h01;
  end
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      gap_r <= 8'h00;
    end else begin
      gap_r <= gap_nxt;
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  property p_refresh_period;
    gap_r <= REFRESH_CYCLES;
  endproperty
  a_refresh_period: assert property (p_refresh_period) else $error("refresh gap too long");
  property p_vol_answer;
    refresh && volatile_write_request |-> ##[1:4] volatile_write_done;
  endproperty
  a_vol_answer: assert property (p_vol_answer) else $error("volatile done late");
  property p_nv_answer;
    refresh && nonvolatile_write_request |-> ##[1:4] nonvolatile_write_done;
  endproperty
  a_nv_answer: assert property (p_nv_answer) else $error("nonvolatile done late");
  property p_vol_drop;
    refresh && !volatile_write_request |-> ##[1:4] !volatile_write_done;
  endproperty
  a_vol_drop: assert property (p_vol_drop) else $error("volatile done stuck");
  property p_nv_drop;
    refresh && !nonvolatile_write_request |-> ##[1:4] !nonvolatile_write_done;
  endproperty
  a_nv_drop: assert property (p_nv_drop) else $error("nonvolatile done stuck");
  property p_vol_cause;
    $rose(volatile_write_done) |-> volatile_write_request && !nonvolatile_write_done;
  endproperty
  a_vol_cause: assert property (p_vol_cause) else $error("volatile done unasked");
  property p_nv_cause;
    $rose(nonvolatile_write_done) |-> nonvolatile_write_request;
  endproperty
  a_nv_cause: assert property (p_nv_cause) else $error("nonvolatile done unasked");
  property p_ins_cause;
    $rose(instruction_done) |-> instruction_execute_request;
  endproperty
  a_ins_cause: assert property (p_ins_cause) else $error("instruction done unasked");
  property p_ins_drop;
    refresh && !instruction_execute_request |-> ##[1:4] !instruction_done;
  endproperty
  a_ins_drop: assert property (p_ins_drop) else $error("instruction done stuck");
  property p_rb_cause;
    !$stable(rd_words) |-> monitor_request;
  endproperty
  a_rb_cause: assert property (p_rb_cause) else $error("read-back changed unasked");
endmodule
`default_nettype wire

// ===== tb/drw_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module drw_tb_top;
  import drw_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hrdy;
  logic        hresp;
  logic [7:0]  ext = 8'h00;
  logic [7:0]  src = 8'h00;
  logic [7:0]  res = 8'h00;
  logic        sgn = 1'b0;
  logic        spd = 1'b0;
  logic        trq = 1'b0;
  logic        vec = 1'b0;
  logic        i_ack = 1'b0;
  logic        m_ack = 1'b0;
  logic [15:0] m_data = 16'h0;
  logic [15:0] f_ram, f_nv, t_vol, t_nv, i_code, i_op;
  logic [7:0]  i_ext, m_code;
  logic [2:0]  f_idx;
  logic        rev, i_req, f_ok, m_req;
  drw_unit_t   unit;
  logic [31:0] q;
  int          err_count = 0;
  int          cmp_count = 0;
  drw_link_if link_if();
  drw_master_end #(.REFRESH_CYCLES(16)) drw_master_end_inst (
    .ref_clk_in(clk), .reset_in(rst), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'b010), .hready_in(hrdy), .hwdata_in(hwdata),
    .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp), .link(link_if));
  drw_drive_end drw_drive_end_inst (
    .ref_clk_in(clk), .reset_in(rst), .link(link_if), .link_extension_setting_in(ext),
    .torque_source_selection_in(src), .sign_selection_param_in(sgn),
    .resolution_switchover_param_in(res), .speed_display_en_in(spd), .torque_control_in(trq),
    .vector_control_in(vec), .freq_ram_out(f_ram), .freq_nv_out(f_nv), .reverse_out(rev),
    .setpoint_unit_out(unit), .torque_value_volatile_param_out(t_vol),
    .torque_value_nonvolatile_param_out(t_nv), .instr_req_out(i_req), .instr_code_out(i_code),
    .instr_ext_out(i_ext), .instr_operand_out(i_op), .instr_ack_in(i_ack),
    .fault_index_out(f_idx), .fault_index_valid_out(f_ok), .mon_code_out(m_code),
    .mon_req_out(m_req), .mon_data_in(m_data), .mon_ack_in(m_ack));
  drw_chk #(.REFRESH_CYCLES(16)) drw_chk_inst (
    .ref_clk_in(clk), .reset_in(rst), .refresh(link_if.refresh), .wr_words(link_if.wr_words),
    .monitor_request(link_if.monitor_request), .rd_words(link_if.rd_words),
    .volatile_write_request(link_if.volatile_write_request),
    .nonvolatile_write_request(link_if.nonvolatile_write_request),
    .instruction_execute_request(link_if.instruction_execute_request),
    .volatile_write_done(link_if.volatile_write_done),
    .nonvolatile_write_done(link_if.nonvolatile_write_done),
    .instruction_done(link_if.instruction_done));
  always #2 clk = ~clk;
  // Monitor source answers every other cycle, data tagged with its code
  always @(posedge clk) begin
    if (m_req && !m_ack) begin
      m_ack  <= 1'b1;
      m_data <= {8'hA5, m_code};
    end else begin
      m_ack <= 1'b0;
    end
  end
  task automatic end_sim;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic hold;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'b1 && n < 50);
    if (hrdy !== 1'b1) begin
      err_count++;
      end_sim();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h000000, a};
    hold();
    htrans <= 2'b00;
    hwdata <= d;
    hold();
    q = hrdata;
    chk("hresp", {15'h0000, hresp}, 16'h0000);
  endtask
  // Polls a register until the masked bits match; link answers take a refresh period
  task automatic poll(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    int n;
    n = 0;
    do begin
      bus(1'b0, a, 32'h0);
      n++;
    end while ((q[15:0] & m) !== e && n < 60);
    chk("poll", q[15:0] & m, e);
    if ((q[15:0] & m) !== e) end_sim();
  endtask
  task automatic commit(input logic [15:0] v, input int b);
    bus(1'b1, 8'h04, {16'h0000, v});
    bus(1'b1, 8'h24, 32'h1 << b);
    poll(8'h28, 16'h1 << (b - 1), 16'h1 << (b - 1));
    bus(1'b1, 8'h24, 32'h0);
    poll(8'h28, 16'h1 << (b - 1), 16'h0000);
  endtask
  task automatic instr(input logic [15:0] c, input logic [15:0] o, input logic [15:0] ec,
                       input logic [7:0] ee);
    int n;
    bus(1'b1, 8'h08, {16'h0000, c});
    bus(1'b1, 8'h0C, {16'h0000, o});
    bus(1'b1, 8'h24, 32'h8);
    n = 0;
    while (i_req !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    if (i_req !== 1'b1) begin
      err_count++;
      end_sim();
    end
    chk("code", i_code, ec);
    chk("ext", {8'h00, i_ext}, {8'h00, ee});
    chk("operand", i_op, o);
    i_ack <= 1'b1;
    @(posedge clk);
    i_ack <= 1'b0;
    poll(8'h28, 16'h0004, 16'h0004);
    bus(1'b1, 8'h24, 32'h0);
    poll(8'h28, 16'h0004, 16'h0000);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, 8'h4C, 32'h0);
    chk("unmapped", q[15:0], 16'h0000);
    commit(16'h9C40, 2);
    chk("nv", f_nv, 16'h9C40);
    commit(16'h9C41, 1);
    chk("ram kept", f_ram, 16'h9C40);
    commit(16'h1234, 1);
    chk("ram", f_ram, 16'h1234);
    chk("nv kept", f_nv, 16'h9C40);
    sgn <= 1'b1;
    commit(16'hFF9C, 1);
    chk("reverse", {15'h0000, rev}, 16'h0001);
    commit(16'h0064, 1);
    chk("forward", {15'h0000, rev}, 16'h0000);
    sgn <= 1'b0;
    spd <= 1'b1;
    commit(16'h0010, 1);
    chk("unit", {14'h0000, unit}, {14'h0000, DRW_UNIT_RPM});
    vec <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      res <= i[0] ? 8'h0B : 8'h01;
      commit(16'h0020, 1);
      chk("unit", {14'h0000, unit}, {14'h0000, DRW_UNIT_DECI_RPM});
    end
    spd <= 1'b0;
    vec <= 1'b0;
    trq <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      ext <= (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : 8'h0C;
      src <= i[0] ? 8'h03 : 8'h05;
      commit(16'h0300 + 16'(i), 1 + i[0]);
      chk("tq ram", t_vol, 16'h0300 + 16'(i));
      chk("tq nv", t_nv, 16'h0300 + 16'(i));
    end
    trq <= 1'b0;
    instr(16'h1234, 16'h5678, 16'h0034, 8'h12);
    ext <= 8'h00;
    instr(16'h0200, 16'h0000, 16'h0200, 8'h00);
    bus(1'b1, 8'h00, 32'h2211);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 8'(8'h10 + 4 * k), {24'h0, 8'(8'h33 + 8'h11 * k)});
    end
    bus(1'b1, 8'h24, 32'h1);
    poll(8'h2C, 16'hFFFF, 16'hA511);
    poll(8'h30, 16'hFFFF, 16'hA522);
    for (int k = 0; k < 4; k++) begin
      poll(8'(8'h3C + 4 * k), 16'hFFFF, {8'hA5, 8'(8'h33 + 8'h11 * k)});
    end
    bus(1'b1, 8'h24, 32'h0);
    for (int j = 0; j < 10; j++) begin
      bus(1'b1, 8'h20, {16'h0, 8'(j), 8'h00});
      repeat (40) @(posedge clk);
      chk("fault", {12'h000, f_ok, f_idx}, j < 8 ? 16'(8 + j) : 16'(j - 8));
    end
    end_sim();
  end
endmodule
`default_nettype wire
